// ### hw/csr_params.svh
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// Register byte offsets on the bus
`define CSR_OFS_STATUS 8'h00
`define CSR_OFS_OPTION 8'h04
`define CSR_OFS_INTCTL 8'h08
`define CSR_OFS_PINCHG 8'h0C
`define CSR_OFS_TIMER 8'h10

// Reset values
`define CSR_RST_STATUS_HI 3'h0
`define CSR_RST_OPTION 8'hFF
`define CSR_RST_INTCTL 8'h00
`define CSR_RST_PINCHG 6'h00

// Arithmetic status fields
`define CSR_ST_BANK 5
`define CSR_ST_TO 4
`define CSR_ST_PD 3
`define CSR_ST_Z 2
`define CSR_ST_DC 1
`define CSR_ST_C 0

// Option fields
`define CSR_OP_PUDIS 7
`define CSR_OP_EDGE 6
`define CSR_OP_TCS 5
`define CSR_OP_TSE 4
`define CSR_OP_PSA 3

// Interrupt control fields
`define CSR_IC_GIE 7
`define CSR_IC_PERIPHERAL_IRQ_ENABLE 6
`define CSR_IC_TIMER_OVERFLOW_IRQ_ENABLE 5
`define CSR_IC_EXT_PIN_IRQ_ENABLE 4
`define CSR_IC_PCIE 3
`define CSR_IC_T0F 2
`define CSR_IC_EXT_PIN_IRQ_FLAG 1
`define CSR_IC_PCF 0

`endif

// ### hw/csr_pkg.sv
package csr_pkg;

    typedef enum logic [2:0] {
        CSR_ALU_ADD,
        CSR_ALU_SUB,
        CSR_ALU_LOGIC,
        CSR_ALU_ROR,
        CSR_ALU_ROL
    } csr_alu_op_t;

endpackage

// ### hw/csr_core_regs.sv
// How it works
// (R1) Flag-affecting instruction writing status keeps flag logic values for Z, DC, C; code keeps only the affected flags, others take result bits.
// (R2) Software writes never change the timeout and power-down flags.
// (R3) Bank select bit 5 picks upper or lower direct data bank.
// (R4) Timeout flag sets on power-up, watchdog clear or sleep; clears on time-out.
// (R5) Power-down flag sets on power-up or watchdog clear; clears on sleep.
// (R6) Zero flag follows whether the operation result is zero.
// (R7) Digit carry shows carry out of bit 3; inverted borrow on subtract.
// (R8) Carry shows carry out of bit 7; subtract adds two's complement.
// (R9) Rotates load carry with the bit shifted out.
// (R10) Pull-up disable bit forces all pull-ups off, else per-pin settings.
// (R11) Edge select picks rising or falling edge of external interrupt pin.
// (R12) Timer clock source picks external pin transitions or instruction clock.
// (R13) Source edge picks falling or rising pin transitions for the timer.
// (R14) Prescaler assignment attaches shared prescaler to watchdog or timer.
// (R15) Rate n divides timer by 2^(n+1), watchdog by 2^n.
// (R16) Software gets undivided timer by assigning prescaler to watchdog.
// (R17) Interrupt flags set on their condition regardless of enables.
// (R18) Global enable gates all interrupts; peripheral enable gates peripheral ones.
// (R19) Per-source enables unmask timer, pin and port change; port needs pin enables.
// (R20) Timer overflow flag sets on rollover, holds until cleared; count not reset.
// (R21) External flag sets on the selected edge, cleared only by software.
// (R22) Port change flag sets when an enabled pin 5..0 changes, holds till cleared.
// (R23) Interrupt request when global enable and any enabled flag set.
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "csr_params.svh"

module csr_core_regs #(
    parameter int PINS = 6
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core datapath
    input wire logic alu_valid,
    input wire csr_pkg::csr_alu_op_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic alu_dest_status,
    output logic [7:0] alu_result,
    input wire logic [6:0] dir_addr,
    output logic [7:0] data_addr,
    // Power and watchdog events
    input wire logic watchdog_clear_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    input wire logic watchdog_base_tick,
    output logic watchdog_tick,
    // Pins
    input wire logic ext_irq_pin,
    input wire logic ext_timer_clock_pin,
    input wire logic [PINS-1:0] port_pins,
    input wire logic [PINS-1:0] pin_pullup_req,
    output logic [PINS-1:0] pullup_enable,
    // Interrupts
    input wire logic periph_irq_pending,
    output logic irq_req
);
    import csr_pkg::*;

    logic [2:0] status_hi;
    logic [2:0] arith_flags;
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic [7:0] option_config;
    logic [7:0] interrupt_control;
    logic [PINS-1:0] pin_change_detect_enables;
    logic [7:0] timer_count;
    logic [7:0] presc_cnt;
    logic ext_irq_prev;
    logic ext_clk_prev;
    logic [PINS-1:0] port_prev;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [7:0] arith_status;
    logic [7:0] rd_val;
    logic [8:0] sum9;
    logic [4:0] dsum5;
    logic [7:0] next_result;
    logic [2:0] fl_val;
    logic [2:0] fl_mask;
    logic addr_ok;
    logic wr_status;
    logic wr_option;
    logic wr_intctl;
    logic wr_pinchg;
    logic wr_timer;
    logic ext_edge;
    logic timer_src_tick;
    logic presc_src_tick;
    logic presc_hit;
    logic timer_inc;
    logic timer_roll;
    logic port_change;
    logic irq_any;

    function automatic logic rate_hit(input logic [7:0] cnt, input logic [3:0] k);
        logic [7:0] mask;
        mask = 8'((9'h001 << k) - 9'h001);
        rate_hit = (cnt & mask) == mask;
    endfunction

    function automatic logic flag_next(input logic cur, input logic set, input logic wr,
                                       input logic wval);
        flag_next = set | (wr ? wval : cur);
    endfunction

    assign arith_status = {status_hi, watchdog_timeout_flag, power_down_flag, arith_flags};

    // Bus address phase and decode
    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_status = dp_wr && (dp_addr == `CSR_OFS_STATUS);
    assign wr_option = dp_wr && (dp_addr == `CSR_OFS_OPTION);
    assign wr_intctl = dp_wr && (dp_addr == `CSR_OFS_INTCTL);
    assign wr_pinchg = dp_wr && (dp_addr == `CSR_OFS_PINCHG);
    assign wr_timer = dp_wr && (dp_addr == `CSR_OFS_TIMER);

    always_comb begin
        case (haddr[7:0])
            `CSR_OFS_STATUS: rd_val = arith_status;
            `CSR_OFS_OPTION: rd_val = option_config;
            `CSR_OFS_INTCTL: rd_val = interrupt_control;
            `CSR_OFS_PINCHG: rd_val = 8'(pin_change_detect_enables);
            `CSR_OFS_TIMER: rd_val = timer_count;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dp_wr <= addr_ok && hwrite;
            if (addr_ok) begin
                dp_addr <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= {24'h00_0000, rd_val};
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ALU flag logic
    always_comb begin
        sum9 = 9'h000;
        dsum5 = 5'h00;
        next_result = 8'h00;
        fl_val = 3'h0;
        fl_mask = 3'h0;
        case (alu_op)
            CSR_ALU_ADD: begin
                sum9 = {1'b0, alu_a} + {1'b0, alu_b};
                dsum5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}; // R7
                next_result = sum9[7:0];
                fl_val[`CSR_ST_C] = sum9[8]; // R8
                fl_val[`CSR_ST_DC] = dsum5[4];
                fl_mask = 3'h7;
            end
            CSR_ALU_SUB: begin
                sum9 = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001; // R8
                dsum5 = {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01; // R7
                next_result = sum9[7:0];
                fl_val[`CSR_ST_C] = sum9[8];
                fl_val[`CSR_ST_DC] = dsum5[4];
                fl_mask = 3'h7;
            end
            CSR_ALU_LOGIC: begin
                next_result = alu_b;
                fl_mask = 3'h4;
            end
            CSR_ALU_ROR: begin
                next_result = {arith_flags[`CSR_ST_C], alu_a[7:1]};
                fl_val[`CSR_ST_C] = alu_a[0]; // R9
                fl_mask = 3'h1;
            end
            CSR_ALU_ROL: begin
                next_result = {alu_a[6:0], arith_flags[`CSR_ST_C]};
                fl_val[`CSR_ST_C] = alu_a[7]; // R9
                fl_mask = 3'h1;
            end
            default: begin
                next_result = 8'h00;
            end
        endcase
        fl_val[`CSR_ST_Z] = (next_result == 8'h00); // R6
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alu_result <= 8'h00;
        end else if (alu_valid) begin
            alu_result <= next_result;
        end
    end

    // Arithmetic status: bank bits and flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_hi <= `CSR_RST_STATUS_HI;
            arith_flags <= 3'h0;
        end else if (alu_valid) begin
            if (alu_dest_status) begin
                status_hi <= next_result[7:5];
            end
            for (int i = 0; i < 3; i++) begin
                if (fl_mask[i]) begin
                    arith_flags[i] <= fl_val[i]; // R1
                end else if (alu_dest_status) begin
                    arith_flags[i] <= next_result[i];
                end
            end
        end else if (wr_status) begin
            status_hi <= hwdata[7:5];
            arith_flags <= hwdata[2:0];
        end
    end

    // Timeout and power-down flags, hardware only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_timeout_flag <= 1'b1; // R4
            power_down_flag <= 1'b1; // R5
        end else begin
            if (watchdog_timeout) begin
                watchdog_timeout_flag <= 1'b0; // R4
            end else if (watchdog_clear_instr || sleep_instr) begin
                watchdog_timeout_flag <= 1'b1; // R4
            end
            if (sleep_instr) begin
                power_down_flag <= 1'b0; // R5
            end else if (watchdog_clear_instr) begin
                power_down_flag <= 1'b1;
            end
        end
    end

    // Direct data address with bank select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_addr <= 8'h00;
        end else begin
            data_addr <= {status_hi[`CSR_ST_BANK-5], dir_addr}; // R3
        end
    end

    // Option and pin change enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            option_config <= `CSR_RST_OPTION;
            pin_change_detect_enables <= `CSR_RST_PINCHG;
        end else begin
            if (wr_option) begin
                option_config <= hwdata[7:0];
            end
            if (wr_pinchg) begin
                pin_change_detect_enables <= hwdata[PINS-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pullup_enable <= '0;
        end else if (option_config[`CSR_OP_PUDIS]) begin
            pullup_enable <= '0; // R10
        end else begin
            pullup_enable <= pin_pullup_req;
        end
    end

    // Pin history for edge and change detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_irq_prev <= 1'b0;
            ext_clk_prev <= 1'b0;
            port_prev <= '0;
        end else begin
            ext_irq_prev <= ext_irq_pin;
            ext_clk_prev <= ext_timer_clock_pin;
            port_prev <= port_pins;
        end
    end

    assign ext_edge = option_config[`CSR_OP_EDGE] ? (ext_irq_pin && !ext_irq_prev)
                                                  : (!ext_irq_pin && ext_irq_prev); // R11
    assign timer_src_tick = !option_config[`CSR_OP_TCS] ? 1'b1 : // R12
                            option_config[`CSR_OP_TSE] ? (!ext_timer_clock_pin && ext_clk_prev)
                                                       : (ext_timer_clock_pin && !ext_clk_prev); // R13
    assign port_change = |((port_pins ^ port_prev) & pin_change_detect_enables); // R22

    // Shared prescaler
    assign presc_src_tick = option_config[`CSR_OP_PSA] ? watchdog_base_tick : timer_src_tick; // R14
    assign presc_hit = rate_hit(presc_cnt, option_config[`CSR_OP_PSA]
                                ? {1'b0, option_config[2:0]}
                                : {1'b0, option_config[2:0]} + 4'h1); // R15
    assign timer_inc = option_config[`CSR_OP_PSA] ? timer_src_tick : (presc_src_tick && presc_hit);
    assign timer_roll = timer_inc && (timer_count == 8'hFF);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_cnt <= 8'h00;
        end else if (wr_timer && !option_config[`CSR_OP_PSA]) begin
            presc_cnt <= 8'h00;
        end else if (presc_src_tick) begin
            presc_cnt <= presc_cnt + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_tick <= 1'b0;
        end else if (option_config[`CSR_OP_PSA]) begin
            watchdog_tick <= watchdog_base_tick && presc_hit; // R15
        end else begin
            watchdog_tick <= watchdog_base_tick;
        end
    end

    // Timer count keeps its value across reset
    always_ff @(posedge hclk) begin
        if (wr_timer) begin
            timer_count <= hwdata[7:0];
        end else if (timer_inc) begin
            timer_count <= timer_count + 8'h01; // R20
        end
    end

    // Interrupt control: enables and sticky flags, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_control <= `CSR_RST_INTCTL;
        end else begin
            if (wr_intctl) begin
                interrupt_control[7:3] <= hwdata[7:3];
            end
            interrupt_control[`CSR_IC_T0F] <= flag_next(interrupt_control[`CSR_IC_T0F],
                timer_roll, wr_intctl, hwdata[`CSR_IC_T0F]); // R17 R20
            interrupt_control[`CSR_IC_EXT_PIN_IRQ_FLAG] <= flag_next(interrupt_control[`CSR_IC_EXT_PIN_IRQ_FLAG],
                ext_edge, wr_intctl, hwdata[`CSR_IC_EXT_PIN_IRQ_FLAG]); // R21
            interrupt_control[`CSR_IC_PCF] <= flag_next(interrupt_control[`CSR_IC_PCF],
                port_change, wr_intctl, hwdata[`CSR_IC_PCF]); // R22
        end
    end

    assign irq_any = (interrupt_control[`CSR_IC_TIMER_OVERFLOW_IRQ_ENABLE] && interrupt_control[`CSR_IC_T0F])
                  || (interrupt_control[`CSR_IC_EXT_PIN_IRQ_ENABLE] && interrupt_control[`CSR_IC_EXT_PIN_IRQ_FLAG])
                  || (interrupt_control[`CSR_IC_PCIE] && interrupt_control[`CSR_IC_PCF]) // R19
                  || (interrupt_control[`CSR_IC_PERIPHERAL_IRQ_ENABLE] && periph_irq_pending); // R18

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= interrupt_control[`CSR_IC_GIE] && irq_any; // R23
        end
    end

    // Assertions
    property p_flags_kept;
        @(posedge hclk) disable iff (!hresetn)
        (alu_valid && alu_dest_status && alu_op == CSR_ALU_ADD)
        |=> arith_status[`CSR_ST_C] == $past(sum9[8]) && arith_status[`CSR_ST_Z] == (alu_result == 8'h00);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("status flags not from flag logic"); // R1

    property p_to_pd_ro;
        @(posedge hclk) disable iff (!hresetn)
        (wr_status && !watchdog_timeout && !watchdog_clear_instr && !sleep_instr)
        |=> $stable(arith_status[4:3]);
    endproperty
    a_to_pd_ro: assert property (p_to_pd_ro) else $error("software changed timeout or power-down"); // R2

    property p_bank_addr;
        @(posedge hclk) disable iff (!hresetn)
        hresetn |=> data_addr == {$past(arith_status[`CSR_ST_BANK]), $past(dir_addr)};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("bank select not steering address"); // R3

    property p_timeout;
        @(posedge hclk) disable iff (!hresetn)
        watchdog_timeout |=> !arith_status[`CSR_ST_TO];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not cleared"); // R4

    property p_sleep;
        @(posedge hclk) disable iff (!hresetn)
        (sleep_instr && !watchdog_timeout) |=> !arith_status[`CSR_ST_PD] && arith_status[`CSR_ST_TO];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not update power flags"); // R5

    property p_rotate_carry;
        @(posedge hclk) disable iff (!hresetn)
        (alu_valid && alu_op == CSR_ALU_ROR) |=> arith_status[`CSR_ST_C] == $past(alu_a[0]);
    endproperty
    a_rotate_carry: assert property (p_rotate_carry) else $error("rotate carry wrong"); // R9

    property p_pullup_off;
        @(posedge hclk) disable iff (!hresetn)
        option_config[`CSR_OP_PUDIS] |=> pullup_enable == '0;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-ups active while disabled"); // R10

    property p_ext_flag;
        @(posedge hclk) disable iff (!hresetn)
        (option_config[`CSR_OP_EDGE] && $rose(ext_irq_pin)) |=> interrupt_control[`CSR_IC_EXT_PIN_IRQ_FLAG];
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("rising edge did not set pin flag"); // R11

    property p_t0f_hold;
        @(posedge hclk) disable iff (!hresetn)
        (interrupt_control[`CSR_IC_T0F] && !wr_intctl) |=> interrupt_control[`CSR_IC_T0F];
    endproperty
    a_t0f_hold: assert property (p_t0f_hold) else $error("overflow flag lost"); // R20

    property p_gie_block;
        @(posedge hclk) disable iff (!hresetn)
        !interrupt_control[`CSR_IC_GIE] |=> !irq_req;
    endproperty
    a_gie_block: assert property (p_gie_block) else $error("request while globally disabled"); // R18

endmodule // csr_core_regs

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "csr_params.svh"

module tb;
    import csr_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic alu_valid, alu_dest_status;
    csr_alu_op_t alu_op;
    logic [7:0] alu_a, alu_b, alu_result, data_addr;
    logic [6:0] dir_addr;
    logic watchdog_clear_instr, sleep_instr, watchdog_timeout, watchdog_base_tick, watchdog_tick;
    logic ext_irq_pin, ext_timer_clock_pin, periph_irq_pending, irq_req;
    logic [5:0] port_pins, pin_pullup_req, pullup_enable;
    logic [31:0] d;
    int err_total, compares, cyc;
    wire hready = hreadyout;

    csr_core_regs #(.PINS(6)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
        .alu_dest_status(alu_dest_status), .alu_result(alu_result),
        .dir_addr(dir_addr), .data_addr(data_addr),
        .watchdog_clear_instr(watchdog_clear_instr), .sleep_instr(sleep_instr),
        .watchdog_timeout(watchdog_timeout), .watchdog_base_tick(watchdog_base_tick),
        .watchdog_tick(watchdog_tick), .ext_irq_pin(ext_irq_pin),
        .ext_timer_clock_pin(ext_timer_clock_pin), .port_pins(port_pins),
        .pin_pullup_req(pin_pullup_req), .pullup_enable(pullup_enable),
        .periph_irq_pending(periph_irq_pending), .irq_req(irq_req)
    );

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task summarize();
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            summarize();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Single AHB-Lite transfers, address phase held until hready
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] wd);
        logic [31:0] dummy;
        xfer(1'b1, a, wd, dummy);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 8'h00, r);
    endtask

    // One instruction result, then result and status flags
    task alu(input csr_alu_op_t op, input logic [7:0] a, b, er, input logic [2:0] ef);
        @(posedge hclk);
        alu_valid <= 1'b1;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        @(posedge hclk);
        alu_valid <= 1'b0;
        #1 chk({24'h0, alu_result}, {24'h0, er});
        rd(`CSR_OFS_STATUS, d);
        chk(d, {24'h0, 5'h03, ef});
    endtask

    task ev(input int k);
        @(posedge hclk);
        case (k)
            0: sleep_instr <= 1'b1;
            1: watchdog_timeout <= 1'b1;
            default: watchdog_clear_instr <= 1'b1;
        endcase
        @(posedge hclk);
        sleep_instr <= 1'b0;
        watchdog_timeout <= 1'b0;
        watchdog_clear_instr <= 1'b0;
    endtask

    task xi(input logic v, input logic e);
        wr(`CSR_OFS_INTCTL, 8'h00);
        ext_irq_pin <= v;
        repeat (3) @(posedge hclk);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[1]}, {31'h0, e});
    endtask

    task iq(input logic [7:0] v, input logic p, input logic e);
        periph_irq_pending <= p;
        wr(`CSR_OFS_INTCTL, v);
        repeat (2) @(posedge hclk);
        #1 chk({31'h0, irq_req}, {31'h0, e});
    endtask

    task tdiff(input int w, input logic pv, input logic [7:0] e);
        logic [31:0] a;
        logic [31:0] b;
        rd(`CSR_OFS_TIMER, a);
        ext_timer_clock_pin <= pv;
        repeat (w) @(posedge hclk);
        rd(`CSR_OFS_TIMER, b);
        chk({24'h0, b[7:0] - a[7:0]}, {24'h0, e});
    endtask

    task wd(input int n, input logic prescaler_assign, input int e);
        logic [31:0] cnt;
        cnt = 0;
        wr(`CSR_OFS_OPTION, {4'h0, prescaler_assign, n[2:0]});
        for (int i = 0; i < 4 * (1 << n) + 4; i++) begin
            @(posedge hclk);
            watchdog_base_tick <= (i < 4 * (1 << n));
            @(negedge hclk);
            cnt += watchdog_tick;
        end
        chk(cnt, e);
    endtask

    initial begin
        {hresetn, hwrite, alu_valid, alu_dest_status, watchdog_clear_instr} = '0;
        {sleep_instr, watchdog_timeout, watchdog_base_tick, ext_irq_pin} = '0;
        {ext_timer_clock_pin, periph_irq_pending, err_total, compares, cyc} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        htrans = 2'h0;
        haddr = '0;
        hwdata = '0;
        alu_op = CSR_ALU_ADD;
        alu_a = '0;
        alu_b = '0;
        dir_addr = 7'h55;
        port_pins = '0;
        pin_pullup_req = 6'h2A;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h18);
        chk({31'h0, hresp}, 32'h0);
        rd(`CSR_OFS_OPTION, d);
        chk(d, 32'hFF);
        rd(`CSR_OFS_INTCTL, d);
        chk(d, 32'h00);
        wr(8'h14, 8'hFF);
        rd(8'h14, d);
        chk(d, 32'h00);
        chk({26'h0, pullup_enable}, 32'h0);
        wr(`CSR_OFS_TIMER, 8'h00);
        alu(CSR_ALU_ADD, 8'h0F, 8'h01, 8'h10, 3'b010);
        alu(CSR_ALU_ADD, 8'hFF, 8'h01, 8'h00, 3'b111);
        alu(CSR_ALU_SUB, 8'h10, 8'h01, 8'h0F, 3'b001);
        alu(CSR_ALU_SUB, 8'h01, 8'h02, 8'hFF, 3'b000);
        alu(CSR_ALU_LOGIC, 8'h00, 8'h00, 8'h00, 3'b100);
        alu(CSR_ALU_ADD, 8'h80, 8'h80, 8'h00, 3'b101);
        alu(CSR_ALU_ROR, 8'h02, 8'h00, 8'h81, 3'b100);
        alu(CSR_ALU_ROL, 8'h80, 8'h00, 8'h00, 3'b101);
        alu(CSR_ALU_LOGIC, 8'h00, 8'h5A, 8'h5A, 3'b001);
        wr(`CSR_OFS_STATUS, 8'h00);
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h18);
        ev(0);
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h10);
        wr(`CSR_OFS_STATUS, 8'h3F);
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h37);
        chk({24'h0, data_addr}, 32'hD5);
        ev(1);
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h27);
        ev(2);
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h3F);
        // Status write landing in the same cycle as a flag-affecting result
        alu_dest_status <= 1'b1;
        fork
            wr(`CSR_OFS_STATUS, 8'h07);
            begin
                repeat (2) @(posedge hclk);
                alu_valid <= 1'b1;
                alu_op <= CSR_ALU_ADD;
                alu_a <= 8'h01;
                alu_b <= 8'h01;
                @(posedge hclk);
                alu_valid <= 1'b0;
            end
        join
        alu_dest_status <= 1'b0;
        rd(`CSR_OFS_STATUS, d);
        chk(d, 32'h18);
        dir_addr <= 7'h2A;
        wr(`CSR_OFS_STATUS, 8'h00);
        repeat (2) @(posedge hclk);
        #1 chk({24'h0, data_addr}, 32'h2A);
        wr(`CSR_OFS_OPTION, 8'h48);
        rd(`CSR_OFS_OPTION, d);
        chk(d, 32'h48);
        #1 chk({26'h0, pullup_enable}, 32'h2A);
        xi(1'b1, 1'b1);
        xi(1'b0, 1'b0);
        wr(`CSR_OFS_OPTION, 8'h08);
        xi(1'b1, 1'b0);
        xi(1'b0, 1'b1);
        repeat (10) @(posedge hclk);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[1]}, 32'h1);
        iq(8'h02, 1'b0, 1'b0);
        iq(8'h12, 1'b0, 1'b0);
        iq(8'h92, 1'b0, 1'b1);
        iq(8'h82, 1'b0, 1'b0);
        iq(8'hC0, 1'b1, 1'b1);
        iq(8'h80, 1'b1, 1'b0);
        iq(8'h40, 1'b0, 1'b0);
        wr(`CSR_OFS_PINCHG, 8'h20);
        port_pins <= 6'h01;
        repeat (3) @(posedge hclk);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[0]}, 32'h0);
        port_pins <= 6'h21;
        repeat (3) @(posedge hclk);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[0]}, 32'h1);
        wr(`CSR_OFS_TIMER, 8'h00);
        wr(`CSR_OFS_INTCTL, 8'h00);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[2]}, 32'h0);
        wr(`CSR_OFS_TIMER, 8'hFE);
        repeat (4) @(posedge hclk);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[2]}, 32'h1);
        repeat (20) @(posedge hclk);
        rd(`CSR_OFS_INTCTL, d);
        chk({31'h0, d[2]}, 32'h1);
        for (int n = 0; n < 8; n++) begin
            wr(`CSR_OFS_OPTION, {5'h00, n[2:0]});
            tdiff(4 * (1 << n) - 3, 1'b0, 8'h02);
        end
        wr(`CSR_OFS_OPTION, 8'h08);
        tdiff(1, 1'b0, 8'h04);
        wr(`CSR_OFS_OPTION, 8'h28);
        tdiff(3, 1'b1, 8'h01);
        tdiff(3, 1'b0, 8'h00);
        wr(`CSR_OFS_OPTION, 8'h38);
        tdiff(3, 1'b1, 8'h00);
        tdiff(3, 1'b0, 8'h01);
        for (int n = 0; n < 8; n++)
            wd(n, 1'b1, 4);
        wd(2, 1'b0, 16);
        summarize();
    end
endmodule // tb

`default_nettype wire
